/* dv/add_and_bitclear_exec_subset_tb.sv */
// testbench: drives the register bus and the fetch model, predicts accumulator, flags and file data
// assumes: exec_core top, fetch_file_model partner, zero-wait bus slave
`timescale 1ns/1ps

module add_and_bitclear_exec_subset_tb
  import exec_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hready, hresp, instr_ready, instr_valid, file_we;
  logic [INSTR_W-1:0] instr;
  logic [FADDR_W-1:0] raddr, waddr;
  logic [DATA_W-1:0] rdata, wdata, acc;
  logic [FLAG_W-1:0] flags;
  logic [31:0] rd;
  int n_errors = 0;
  int n_tests = 0;
  int n_exec = 0;  // supported words executed so far

  always #5 clk = ~clk;

  exec_core i_exec_core (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_INSTR(instr),
    .I_INSTR_VALID(instr_valid), .O_INSTR_READY(instr_ready), .O_FILE_RADDR(raddr),
    .I_FILE_RDATA(rdata), .O_FILE_WE(file_we), .O_FILE_WADDR(waddr), .O_FILE_WDATA(wdata),
    .O_ACC(acc), .O_FLAGS(flags));

  fetch_file_model i_fetch_file_model (.i_clk(clk), .i_rst_n(rst_n), .i_ready(instr_ready),
    .i_raddr(raddr), .i_we(file_we), .i_waddr(waddr), .i_wdata(wdata), .o_instr(instr),
    .o_valid(instr_valid), .o_rdata(rdata));

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic finish_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ----------------------------------------
  // bus master: holds each phase until hready is seen high
  // ----------------------------------------
  task automatic bus_wait;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_errors++;
      finish_test;
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    bus_wait;
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait;
    r = hrdata;
    // select stays up between calls with htrans idle, so back-to-back calls never drive it twice in one step
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask

  // ----------------------------------------
  // reference: expected accumulator, flags and file value for one word
  // ----------------------------------------
  function automatic void predict(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] a, fv,
      input logic [FLAG_W-1:0] fl, output logic [DATA_W-1:0] ea, ef, output logic [FLAG_W-1:0] efl,
      output logic known);
    logic [DATA_W-1:0] op, r;
    logic [DATA_W:0] s;
    logic [4:0] nib;
    logic lit;
    ea = a;
    ef = fv;
    efl = fl;
    known = 1'b1;
    lit = (w[13:12] == 2'b11);
    op = lit ? w[7:0] : fv;
    s = {1'b0, a} + {1'b0, op};
    nib = {1'b0, a[3:0]} + {1'b0, op[3:0]};
    r = a & op;
    if (w[13:9] == ADD_LIT_PAT || w[13:8] == ADD_REG_PAT) begin
      r = s[7:0];
      efl = {r == 8'h00, nib[4], s[8]};
    end else if (w[13:8] == MASK_LIT_PAT || w[13:8] == MASK_REG_PAT) begin
      efl[ZERO_POS] = (r == 8'h00);
    end else begin
      // bit clear is read-modify-write of the file value; anything else has no effect
      known = (w[13:10] == BCLR_PAT);
      if (known) begin
        ef = fv & ~(8'h01 << w[9:7]);
      end
      return;
    end
    if (lit || !w[DEST_BIT]) begin
      ea = r;
    end else begin
      ef = r;
    end
  endfunction

  // wait until the offered word is consumed and its file write has landed
  task automatic wait_idle;
    int k;
    k = 0;
    while ((i_fetch_file_model.q.size() != 0 || instr_valid) && k < 40) begin
      @(posedge clk);
      k++;
    end
    if (i_fetch_file_model.q.size() != 0 || instr_valid) begin
      n_errors++;
      finish_test;
    end
    repeat (3) @(posedge clk);
  endtask

  // preset operands, execute one word, compare ports, file and accumulator register
  task automatic run_op(input logic [INSTR_W-1:0] w, input logic [DATA_W-1:0] a, fv,
      input logic [FLAG_W-1:0] fl);
    logic [DATA_W-1:0] ea, ef;
    logic [FLAG_W-1:0] efl;
    logic known;
    ahb(1'b1, ACC_OFS, {24'h0, a}, rd);
    ahb(1'b1, FLAGS_OFS, {29'h0, fl}, rd);
    i_fetch_file_model.mem[w[6:0]] = fv;
    predict(w, a, fv, fl, ea, ef, efl, known);
    n_exec += int'(known);
    i_fetch_file_model.q.push_back(w);
    wait_idle;
    chk("accumulator", {24'h0, ea}, {24'h0, acc});
    chk("flags", {29'h0, efl}, {29'h0, flags});
    chk("file register", {24'h0, ef}, {24'h0, i_fetch_file_model.mem[w[6:0]]});
    ahb(1'b0, ACC_OFS, '0, rd);
    chk("accumulator register", {24'h0, ea}, rd);
  endtask

  // ----------------------------------------
  // steps
  // ----------------------------------------
  task automatic check_step;
    int k;
    // find a first ready pulse, bounded so a stuck divider cannot hang the run
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (instr_ready !== 1'b1 && k < 20);
    if (instr_ready !== 1'b1) begin
      n_errors++;
      finish_test;
    end
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (instr_ready !== 1'b1 && k < 20);
    chk("step spacing", 32'(OSC_PER_INSTR), 32'(k));
    @(posedge clk);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // write the unmapped offset, then check that every offset, that one included, reads its zero reset value
    ahb(1'b1, 8'h10, 32'hffffffff, rd);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, 8'(4 * i), '0, rd);
      chk("reset value", 32'h0, rd);
    end
    // a word is held while halted, then executes once run is set
    i_fetch_file_model.q.push_back(14'h3e01);
    repeat (12) @(posedge clk);
    chk("held word", 32'h1, {31'h0, instr_valid});
    chk("accumulator halted", 32'h0, {24'h0, acc});
    ahb(1'b1, CTRL_OFS, 32'h1, rd);
    wait_idle;
    n_exec = 1;
    chk("first add", 32'h1, {24'h0, acc});
    check_step;
    run_op(14'h3e15, 8'h10, 8'h00, 3'h0);
    run_op(14'h3ff8, 8'h08, 8'h00, 3'h0);
    run_op(14'h395f, 8'ha3, 8'h00, 3'h3);
    run_op(14'h3900, 8'hff, 8'h00, 3'h0);
    run_op(14'h077f, 8'h17, 8'hc2, 3'h0);
    run_op(14'h0780, 8'h80, 8'h80, 3'h0);
    run_op(14'h073a, 8'h0f, 8'h01, 3'h7);
    run_op(14'h0584, 8'h17, 8'hc2, 3'h3);
    run_op(14'h0510, 8'h0f, 8'hf0, 3'h3);
    for (int b = 0; b < 8; b++) begin
      run_op(14'h1000 | 14'(b << 7) | 14'(8'h78 + b), 8'h55, 8'hff, 3'(b));
    end
    run_op(14'h13a0, 8'h00, 8'hc7, 3'h7);
    // a word outside the five forms: sticky bit set, count unchanged, then cleared
    run_op(14'h0000, 8'h33, 8'h44, 3'h5);
    ahb(1'b0, STAT_OFS, '0, rd);
    chk("status after foreign word", {16'h0, 8'(n_exec), 8'h01}, rd);
    ahb(1'b1, STAT_OFS, 32'h1, rd);
    ahb(1'b0, STAT_OFS, '0, rd);
    chk("status cleared", {16'h0, 8'(n_exec), 8'h00}, rd);
    finish_test;
  end
endmodule

/* dv/fetch_file_model.sv */
// partner model: fetch path offering queued words, plus the 128-entry file register space
// assumes: the bench pushes words into q and preloads mem only while no word is in flight
`timescale 1ns/1ps

module fetch_file_model
  import exec_pkg::*;
(
  input wire logic i_clk,                  // system clock
  input wire logic i_rst_n,                // async reset, active low
  input wire logic i_ready,                // word taken when high with valid
  input wire logic [FADDR_W-1:0] i_raddr,  // file read address
  input wire logic i_we,                   // file write strobe
  input wire logic [FADDR_W-1:0] i_waddr,  // file write address
  input wire logic [DATA_W-1:0] i_wdata,   // file write data
  output logic [INSTR_W-1:0] o_instr,      // offered word
  output logic o_valid,                    // word offered
  output logic [DATA_W-1:0] o_rdata        // file read data
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [DATA_W-1:0] mem [0:127];  // file registers 0..127
  logic [INSTR_W-1:0] q [$];       // words waiting to be offered

  // combinational read: the core samples it in the fire cycle
  assign o_rdata = mem[i_raddr];

  // one word at a time; a taken word is replaced by its inverse so a stale word never looks valid
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_valid <= 1'b0;
      o_instr <= '0;
    end else if (o_valid && i_ready) begin
      o_valid <= 1'b0;
      o_instr <= ~o_instr;
    end else if (!o_valid && q.size() != 0) begin
      o_valid <= 1'b1;
      o_instr <= q.pop_front();
    end
  end

  // file writes land on the edge where the strobe is seen
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // known contents, so an unintended write shows up as a mismatch
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = '0;
    end
  end
endmodule

/* logic/exec_core.sv */
// top: instruction-cycle execute block for add, mask and bit-clear words, with an AHB-Lite register slave
// assumes: fetch path offers one word with valid/ready; file registers read combinationally outside
//
// How it works
// RULE1: literal add updates accumulator, carry, nibble, zero
// RULE2: literal mask updates accumulator and zero only
// RULE3: register add sets carry, nibble carry, zero
// RULE4: register mask updates zero flag only
// RULE5: destination bit zero accumulator, one register
// RULE6: low seven bits address file register
// RULE7: bit clear touches one bit, no flags
// RULE8: each word completes in one four-clock cycle
// RULE9: zero, bit7 carry, bit3 nibble carry semantics
`timescale 1ns/1ps

module exec_core
  import exec_pkg::*;
(
  input wire logic I_SYS_CLK,                   // system clock, 100 MHz
  input wire logic I_RST_N,                     // asynchronous reset, active low
  input wire logic I_HSEL,                      // slave select
  input wire logic [31:0] I_HADDR,              // byte address
  input wire logic [1:0] I_HTRANS,              // transfer type
  input wire logic I_HWRITE,                    // write not read
  input wire logic [2:0] I_HSIZE,               // transfer size, word only
  input wire logic [31:0] I_HWDATA,             // write data
  input wire logic I_HREADY,                    // bus ready
  output logic [31:0] O_HRDATA,                 // read data
  output logic O_HREADYOUT,                     // never stalls
  output logic O_HRESP,                         // always okay
  input wire logic [INSTR_W-1:0] I_INSTR,       // fetched word
  input wire logic I_INSTR_VALID,               // fetched word present
  output logic O_INSTR_READY,                   // word taken this cycle if I_INSTR_VALID is high
  output logic [FADDR_W-1:0] O_FILE_RADDR,      // file read address
  input wire logic [DATA_W-1:0] I_FILE_RDATA,   // file read data
  output logic O_FILE_WE,                       // file write strobe
  output logic [FADDR_W-1:0] O_FILE_WADDR,      // file write address
  output logic [DATA_W-1:0] O_FILE_WDATA,       // file write data
  output logic [DATA_W-1:0] O_ACC,              // accumulator
  output logic [FLAG_W-1:0] O_FLAGS             // carry, nibble carry, zero
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [1:0] phase_reg;                  // clock period within the instruction cycle
  logic run_reg;                          // software run enable
  logic [DATA_W-1:0] acc_reg;             // accumulator
  logic [DATA_W-1:0] acc_next;
  logic [FLAG_W-1:0] flags_reg;           // status flags
  logic [FLAG_W-1:0] flags_next;
  logic unsup_reg;                        // sticky: a foreign word was consumed
  logic [7:0] cnt_reg;                    // executed word count, wraps
  logic fwe_reg;                          // file write strobe
  logic [FADDR_W-1:0] fwaddr_reg;         // file write address
  logic [DATA_W-1:0] fwdata_reg;          // file write data
  logic dph_reg;                          // bus data phase pending
  logic dwr_reg;                          // pending phase is a write
  logic [7:0] daddr_reg;                  // pending register offset

  exec_if ex ();                          // operands and results to the unit

  exec_unit u_exec (
    .x(ex.unit)
  );

  // ----------------------------------------
  // instruction cycle divider and handshake
  // ----------------------------------------
  wire step;                              // one pulse every four clocks
  wire fire;                              // a word is executed now

  assign step = (phase_reg == PHASE_LAST); // RULE8
  assign O_INSTR_READY = run_reg && step;
  assign fire = O_INSTR_READY && I_INSTR_VALID;

  // the file address comes straight from the word, so the read is done within the cycle
  assign O_FILE_RADDR = I_INSTR[FADDR_W-1:0]; // RULE6
  assign ex.instr = I_INSTR;
  assign ex.acc = acc_reg;
  assign ex.fdata = I_FILE_RDATA;
  assign ex.flags = flags_reg;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire addr_ok;                           // address phase taken
  wire wr_ctrl;                           // write strobes per register
  wire wr_acc;
  wire wr_flags;
  wire wr_stat;

  assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;
  assign wr_ctrl = dph_reg && dwr_reg && (daddr_reg == CTRL_OFS);
  assign wr_acc = dph_reg && dwr_reg && (daddr_reg == ACC_OFS);
  assign wr_flags = dph_reg && dwr_reg && (daddr_reg == FLAGS_OFS);
  assign wr_stat = dph_reg && dwr_reg && (daddr_reg == STAT_OFS);
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = 1'b0;

  // read mux; unmapped offsets read zero
  always_comb begin
    if (daddr_reg == CTRL_OFS) begin
      O_HRDATA = {31'h0, run_reg};
    end else if (daddr_reg == ACC_OFS) begin
      O_HRDATA = {24'h0, acc_reg};
    end else if (daddr_reg == FLAGS_OFS) begin
      O_HRDATA = {29'h0, flags_reg};
    end else if (daddr_reg == STAT_OFS) begin
      O_HRDATA = {16'h0, cnt_reg, 7'h0, unsup_reg};
    end else begin
      O_HRDATA = 32'h0;
    end
  end

  // ----------------------------------------
  // next values: execution wins over a software write in the same cycle
  // ----------------------------------------
  assign acc_next = (fire && ex.acc_we) ? ex.result : (wr_acc ? I_HWDATA[DATA_W-1:0] : acc_reg); // RULE5
  assign flags_next = (fire && ex.known) ? ex.flags_new :
                      (wr_flags ? I_HWDATA[FLAG_W-1:0] : flags_reg); // RULE9

  // ----------------------------------------
  // bus address phase capture
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dph_reg <= 1'b0;
      dwr_reg <= 1'b0;
      daddr_reg <= 8'h00;
    end else if (I_HREADY) begin
      dph_reg <= addr_ok;
      dwr_reg <= addr_ok && I_HWRITE;
      daddr_reg <= addr_ok ? I_HADDR[7:0] : daddr_reg;
    end
  end

  // ----------------------------------------
  // divider and software control
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      phase_reg <= 2'h0;
      run_reg <= CTRL_RST;
    end else begin
      phase_reg <= phase_reg + 2'h1;      // wraps at four
      if (wr_ctrl) begin
        run_reg <= I_HWDATA[0];
      end
    end
  end

  // ----------------------------------------
  // architectural state
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      acc_reg <= ACC_RST;
      flags_reg <= FLAGS_RST;
    end else begin
      acc_reg <= acc_next;
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------
  // status: a foreign word setting the flag beats a clear in the same cycle
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      unsup_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else begin
      unsup_reg <= (fire && !ex.known) || (unsup_reg && !(wr_stat && I_HWDATA[UNSUP_POS]));
      cnt_reg <= (fire && ex.known) ? cnt_reg + 8'h01 : cnt_reg;
    end
  end

  // ----------------------------------------
  // file write-back, one clock after the step
  // ----------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fwe_reg <= 1'b0;
      fwaddr_reg <= 7'h00;
      fwdata_reg <= 8'h00;
    end else begin
      fwe_reg <= fire && ex.file_we;      // RULE5 RULE7
      if (fire && ex.file_we) begin
        fwaddr_reg <= I_INSTR[FADDR_W-1:0]; // RULE6
        fwdata_reg <= ex.result;
      end
    end
  end

  assign O_FILE_WE = fwe_reg;
  assign O_FILE_WADDR = fwaddr_reg;
  assign O_FILE_WDATA = fwdata_reg;
  assign O_ACC = acc_reg;
  assign O_FLAGS = flags_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  op_t op_now;                            // decode seen by the checks
  assign op_now = op_decode(I_INSTR);

  lit_add_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE1
    fire && op_now == OP_ADD_LIT |=> O_ACC == 8'($past(acc_reg) + $past(I_INSTR[7:0])))
    else $error("literal add gave wrong accumulator");

  lit_mask_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE2
    fire && op_now == OP_MASK_LIT |=> O_ACC == ($past(acc_reg) & $past(I_INSTR[7:0]))
      && O_FLAGS[1:0] == $past(flags_reg[1:0]))
    else $error("literal mask wrong or touched carry");

  reg_add_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE3
    fire && op_now == OP_ADD_REG |=> O_FLAGS[CARRY_POS] ==
      ((9'($past(acc_reg)) + 9'($past(I_FILE_RDATA))) > 9'h0ff))
    else $error("register add carry wrong");

  reg_mask_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE4
    fire && op_now == OP_MASK_REG |=> O_FLAGS[1:0] == $past(flags_reg[1:0]))
    else $error("register mask touched carry flags");

  dest_route_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE5
    fire && (op_now == OP_ADD_REG || op_now == OP_MASK_REG) && I_INSTR[DEST_BIT]
      |=> O_FILE_WE && O_ACC == $past(acc_reg))
    else $error("destination one did not go to the file");

  file_addr_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE6
    O_FILE_WE |-> O_FILE_WADDR == $past(I_INSTR[6:0]))
    else $error("file write address not from low bits");

  bit_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE7
    fire && op_now == OP_BCLR |=> O_FILE_WE
      && O_FILE_WDATA == ($past(I_FILE_RDATA) & ~(8'h01 << $past(I_INSTR[9:7])))
      && O_FLAGS == $past(flags_reg))
    else $error("bit clear result or flags wrong");

  step_spacing_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE8
    step |=> !step [*3] ##1 step)
    else $error("instruction cycle is not four clocks");

  zero_flag_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE9
    fire && ex.acc_we |=> O_FLAGS[ZERO_POS] == (O_ACC == 8'h00))
    else $error("zero flag disagrees with result");

endmodule

/* logic/exec_if.sv */
// interface: operands and results between the core shell and the execute unit
// assumes: purely combinational exchange within one clock cycle
`timescale 1ns/1ps

interface exec_if;
  import exec_pkg::*;
  logic [INSTR_W-1:0] instr;    // word being executed
  logic [DATA_W-1:0] acc;       // current accumulator
  logic [DATA_W-1:0] fdata;     // addressed file register value
  logic [FLAG_W-1:0] flags;     // current flags
  logic acc_we;                 // result goes to the accumulator
  logic file_we;                // result goes to the file register
  logic [DATA_W-1:0] result;    // computed value
  logic [FLAG_W-1:0] flags_new; // flags after the operation
  logic known;                  // word belongs to this block

  modport core (output instr, acc, fdata, flags, input acc_we, file_we, result, flags_new, known);
  modport unit (input instr, acc, fdata, flags, output acc_we, file_we, result, flags_new, known);
endinterface

/* logic/exec_pkg.sv */
// package: constants, opcode patterns and types for the add/mask/bit-clear execute block
// assumes: 14-bit instruction words, 8-bit data, 128-entry file register space outside

package exec_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int INSTR_W = 14;           // instruction word width
  localparam int DATA_W = 8;             // accumulator and file register width
  localparam int FADDR_W = 7;            // file register address width, registers 0..127

  // ----------------------------------------
  // instruction fields
  // ----------------------------------------
  localparam int DEST_BIT = 7;           // destination select sits just above the address
  localparam int BITPOS_LSB = 7;         // bit position field of the bit-clear word
  localparam int BITPOS_W = 3;           // bit position 0..7

  // opcode patterns in the top bits
  localparam logic [4:0] ADD_LIT_PAT = 5'h1f;   // 11 111x
  localparam logic [5:0] MASK_LIT_PAT = 6'h39;  // 11 1001
  localparam logic [5:0] ADD_REG_PAT = 6'h07;   // 00 0111
  localparam logic [5:0] MASK_REG_PAT = 6'h05;  // 00 0101
  localparam logic [3:0] BCLR_PAT = 4'h4;       // 01 00bb

  // ----------------------------------------
  // flag positions
  // ----------------------------------------
  localparam int FLAG_W = 3;             // carry, nibble carry, zero
  localparam int CARRY_POS = 0;          // carry out of bit 7
  localparam int NCARRY_POS = 1;         // carry out of bit 3
  localparam int ZERO_POS = 2;           // result all zeros

  // ----------------------------------------
  // timing: one instruction cycle is four clock periods
  // ----------------------------------------
  localparam int OSC_PER_INSTR = 4;      // clock periods per instruction cycle
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_INSTR - 1); // phase that carries the step

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;  // bit0 run enable
  localparam logic [7:0] ACC_OFS = 8'h04;   // accumulator
  localparam logic [7:0] FLAGS_OFS = 8'h08; // status flags
  localparam logic [7:0] STAT_OFS = 8'h0c;  // bit0 unsupported seen (w1c), [15:8] executed count

  localparam logic CTRL_RST = 1'b0;                  // halted after reset
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;     // accumulator reset value
  localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;    // flags reset value
  localparam int UNSUP_POS = 0;                      // sticky unsupported bit
  localparam int CNT_LSB = 8;                        // executed count position

  // ----------------------------------------
  // operation decode
  // ----------------------------------------
  typedef enum {
    OP_NONE,
    OP_ADD_LIT,
    OP_MASK_LIT,
    OP_ADD_REG,
    OP_MASK_REG,
    OP_BCLR
  } op_t;

  // classify a word; everything else is outside this block
  function automatic op_t op_decode(input logic [INSTR_W-1:0] w);
    op_t op;
    op = OP_NONE;
    if (w[13:9] == ADD_LIT_PAT) begin
      op = OP_ADD_LIT;
    end else if (w[13:8] == MASK_LIT_PAT) begin
      op = OP_MASK_LIT;
    end else if (w[13:8] == ADD_REG_PAT) begin
      op = OP_ADD_REG;
    end else if (w[13:8] == MASK_REG_PAT) begin
      op = OP_MASK_REG;
    end else if (w[13:10] == BCLR_PAT) begin
      op = OP_BCLR;
    end
    return op;
  endfunction

endpackage

/* logic/exec_unit.sv */
// execute unit: computes result, destination and flags for one decoded word
// assumes: operands are stable for the cycle in which the shell commits
`timescale 1ns/1ps

module exec_unit
  import exec_pkg::*;
(
  exec_if.unit x  // operands in, results out
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  op_t op;                                 // operation class
  wire is_lit;                             // literal operand form
  wire is_add;                             // addition form
  wire dest_file;                          // destination bit
  wire [DATA_W-1:0] opnd;                  // second operand
  wire [BITPOS_W-1:0] bitpos;              // bit to clear
  wire [DATA_W:0] sum9;                    // sum with carry out of bit 7
  wire [4:0] nib5;                         // low nibble sum with carry out of bit 3
  wire [DATA_W-1:0] anded;                 // bitwise and
  wire [DATA_W-1:0] cleared;               // file value with one bit cleared
  wire zero;                               // result is all zeros

  assign op = op_decode(x.instr);
  assign is_lit = (op == OP_ADD_LIT) || (op == OP_MASK_LIT);
  assign is_add = (op == OP_ADD_LIT) || (op == OP_ADD_REG);
  assign dest_file = x.instr[DEST_BIT];   // RULE5 RULE6
  assign bitpos = x.instr[BITPOS_LSB +: BITPOS_W]; // RULE7
  // literal sits in the low byte, register forms use the fetched file value
  assign opnd = is_lit ? x.instr[DATA_W-1:0] : x.fdata;

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  assign sum9 = {1'b0, x.acc} + {1'b0, opnd};                 // RULE1 RULE3
  assign nib5 = {1'b0, x.acc[3:0]} + {1'b0, opnd[3:0]};       // RULE9
  assign anded = x.acc & opnd;                                // RULE2 RULE4
  assign cleared = x.fdata & ~(8'h01 << bitpos);              // RULE7

  assign x.result = (op == OP_BCLR) ? cleared : (is_add ? sum9[DATA_W-1:0] : anded);
  assign zero = (x.result == 8'h00);                          // RULE9

  // ----------------------------------------
  // destination and flags
  // ----------------------------------------
  assign x.known = (op != OP_NONE);
  assign x.acc_we = is_lit || (((op == OP_ADD_REG) || (op == OP_MASK_REG)) && !dest_file); // RULE5
  assign x.file_we = (op == OP_BCLR) ||
                     (((op == OP_ADD_REG) || (op == OP_MASK_REG)) && dest_file);         // RULE5

  // adds touch all three flags, masks only zero, bit clear none
  assign x.flags_new = is_add ? {zero, nib5[4], sum9[DATA_W]} :                          // RULE1 RULE3
                       (x.known && (op != OP_BCLR)) ? {zero, x.flags[NCARRY_POS], x.flags[CARRY_POS]} : // RULE2 RULE4
                       x.flags;                                                            // RULE7

endmodule
